// ===== rtl/pin_sync.sv
// Two-flop synchroniser for one pin with a rising/falling edge output.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "stop_seq_regs.svh"
module pin_sync (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pin side.
    input wire logic pin,
    // Synchronised side.
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    // The first flop is read only by the second one.
    always_comb begin
        next_meta = pin;
        next_sync = meta;
        next_prev = sync;
    end

    // Reset to idle high so a button released high gives no false edge.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta <= `SYNC_RESET;
            sync <= `SYNC_RESET;
            prev <= `SYNC_RESET;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule
`default_nettype wire

// ===== rtl/safety_stop_sequencer.sv
// Safety stop sequencer: door stop, delayed emergency stop, operational stop.
// Assumes pushbutton and door inputs are asynchronous; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "stop_seq_regs.svh"
module safety_stop_sequencer
    import stop_seq_pkg::*;
#(
    parameter int STANDSTILL_MS = `STANDSTILL_MS,
    parameter int STANDSTILL_CYCLES = STANDSTILL_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Safety inputs, low asks for a stop.
    input wire logic guard_door_closed_in,
    input wire logic emergency_stop_ok_in,
    // Operator buttons; stop is a normally closed contact, low when pressed.
    input wire logic op_stop_ok_in,
    input wire logic start_in,
    input wire logic ack_in,
    // Outputs to the contactors and the converter.
    output logic main_contactor_a,
    output logic main_contactor_b,
    output logic drive_run_command
);
    localparam int CNT_W = $clog2(STANDSTILL_CYCLES + 1);

    logic door_ok;
    logic estop_ok;
    logic stop_ok;
    logic start_rise;
    logic ack_fall;
    seq_state_type state;
    seq_state_type next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] next_wait_cnt;
    logic next_contactor;
    logic next_run;
    logic door_open;
    logic estop_on;
    logic op_stop;

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************

    pin_sync u_door (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pin(guard_door_closed_in),
        .level(door_ok), .rise(), .fall()
    );
    pin_sync u_estop (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pin(emergency_stop_ok_in),
        .level(estop_ok), .rise(), .fall()
    );
    pin_sync u_stop (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pin(op_stop_ok_in),
        .level(stop_ok), .rise(), .fall()
    );
    pin_sync u_start (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pin(start_in),
        .level(), .rise(start_rise), .fall()
    );
    pin_sync u_ack (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pin(ack_in),
        .level(), .fall(ack_fall), .rise()
    );

    assign door_open = (door_ok == `STOP_ACTIVE);
    assign estop_on = (estop_ok == `STOP_ACTIVE);
    assign op_stop = (stop_ok == `STOP_ACTIVE);

    // ********************************************************************
    // Sequencer
    // ********************************************************************

    // Next state; the door check comes first so it wins over everything.
    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        if (door_open) begin
            next_state = st_tripped;
        end else begin
            unique case (state)
                // Power-up and every trip wait here for an acknowledgement.
                st_locked, st_tripped: begin
                    if (ack_fall && !estop_on) begin
                        next_state = st_powered;
                    end
                end
                st_powered: begin
                    if (estop_on) begin
                        next_state = st_estop_wait;
                        next_wait_cnt = CNT_W'(STANDSTILL_CYCLES);
                    end else if (start_rise && !op_stop) begin
                        next_state = st_running;
                    end
                end
                st_running: begin
                    if (estop_on) begin
                        next_state = st_estop_wait;
                        next_wait_cnt = CNT_W'(STANDSTILL_CYCLES);
                    end else if (op_stop) begin
                        next_state = st_powered;
                    end
                end
                // Contactors stay in while the motor ramps down.
                st_estop_wait: begin
                    if (wait_cnt <= CNT_W'(1)) begin
                        next_state = st_tripped;
                        next_wait_cnt = '0;
                    end else begin
                        next_wait_cnt = wait_cnt - CNT_W'(1);
                    end
                end
            endcase
        end
        next_contactor = (next_state == st_powered) || (next_state == st_running)
            || (next_state == st_estop_wait);
        next_run = (next_state == st_running);
    end

    // Outputs are flops so they never glitch toward the contactor coils.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= st_locked;
            wait_cnt <= '0;
            main_contactor_a <= `OUT_RESET;
            main_contactor_b <= `OUT_RESET;
            drive_run_command <= `OUT_RESET;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            main_contactor_a <= next_contactor;
            main_contactor_b <= next_contactor;
            drive_run_command <= next_run;
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************

    property p_door_cut;
        @(posedge sys_clk) disable iff (sys_rst)
        door_open |=> !main_contactor_a && !main_contactor_b;
    endproperty
    a_door_cut: assert property (p_door_cut) else $error("door open left power on");

    property p_door_run;
        @(posedge sys_clk) disable iff (sys_rst)
        door_open |=> !drive_run_command;
    endproperty
    a_door_run: assert property (p_door_run) else $error("door open left run on");

    property p_door_first;
        @(posedge sys_clk) disable iff (sys_rst)
        (door_open && (ack_fall || start_rise)) |=> state == st_tripped;
    endproperty
    a_door_first: assert property (p_door_first) else $error("door lost priority");

    property p_estop_run;
        @(posedge sys_clk) disable iff (sys_rst)
        (estop_on && !door_open && state == st_running) |=>
            !drive_run_command && main_contactor_a && main_contactor_b;
    endproperty
    a_estop_run: assert property (p_estop_run) else $error("estop reaction wrong");

    property p_estop_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_estop_wait && wait_cnt > CNT_W'(1) && !door_open) |=> main_contactor_a;
    endproperty
    a_estop_hold: assert property (p_estop_hold) else $error("early contactor drop");

    property p_estop_load;
        @(posedge sys_clk) disable iff (sys_rst)
        ($rose(state == st_estop_wait)) |-> wait_cnt == CNT_W'(STANDSTILL_CYCLES);
    endproperty
    a_estop_load: assert property (p_estop_load) else $error("delay not loaded");

    property p_estop_block;
        @(posedge sys_clk) disable iff (sys_rst)
        estop_on |=> !drive_run_command;
    endproperty
    a_estop_block: assert property (p_estop_block) else $error("run during estop");

    property p_need_ack;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_tripped && !ack_fall) |=> !main_contactor_a;
    endproperty
    a_need_ack: assert property (p_need_ack) else $error("power without ack");

    property p_ack_on;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_locked && ack_fall && !estop_on && !door_open) |=>
            main_contactor_a && main_contactor_b;
    endproperty
    a_ack_on: assert property (p_ack_on) else $error("ack did not power");

    property p_start;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_powered && start_rise && !op_stop && !estop_on && !door_open)
            |=> drive_run_command;
    endproperty
    a_start: assert property (p_start) else $error("start ignored");

    property p_op_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_running && op_stop && !estop_on && !door_open) |=>
            !drive_run_command && main_contactor_b;
    endproperty
    a_op_stop: assert property (p_op_stop) else $error("operational stop wrong");

    property p_powerup;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == st_locked && !ack_fall) |=> !drive_run_command && !main_contactor_a;
    endproperty
    a_powerup: assert property (p_powerup) else $error("start before ack");

    property p_run_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        drive_run_command |-> main_contactor_a && main_contactor_b;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("run without power");

    c_run: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(drive_run_command));
    c_door: cover property (@(posedge sys_clk) disable iff (sys_rst)
        drive_run_command ##1 (door_open && !main_contactor_a));
    c_estop: cover property (@(posedge sys_clk) disable iff (sys_rst)
        state == st_estop_wait ##1 state == st_tripped);
    c_opstop: cover property (@(posedge sys_clk) disable iff (sys_rst)
        state == st_running ##1 state == st_powered);
endmodule
`default_nettype wire

// ===== rtl/stop_seq_pkg.sv
// Types of the safety stop sequencer.
// Assumes nothing of its surroundings.
package stop_seq_pkg;
    // Sequencer states.
    typedef enum logic [2:0] {
        st_locked,
        st_powered,
        st_running,
        st_estop_wait,
        st_tripped
    } seq_state_type;
endpackage

// ===== rtl/stop_seq_regs.svh
// Constants of the safety stop sequencer: timing figures and reset values.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef STOP_SEQ_REGS_SVH
`define STOP_SEQ_REGS_SVH

// Clock period in nanoseconds.
`define CLK_PERIOD_NS 10
// Nanoseconds in one millisecond, to turn the standstill time into cycles.
`define NS_PER_MS 1_000_000
// Default standstill delay in milliseconds.
`define STANDSTILL_MS 6000
// Reset value of every output flop (contactors and run command).
`define OUT_RESET 1'b0
// Reset value of the input synchroniser flops (inputs other than start idle high after release).
`define SYNC_RESET 1'b1
// Level of a stop input that asks for a stop.
`define STOP_ACTIVE 1'b0

`endif

// ===== verification/operator_panel.sv
// Operator panel model: door contact, stop buttons, start and acknowledge.
// Assumes the bench calls its tasks; pins change 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module operator_panel (
    // Clock.
    input wire logic sys_clk,
    // Pins towards the sequencer.
    output logic guard_door_closed_in,
    output logic emergency_stop_ok_in,
    output logic op_stop_ok_in,
    output logic start_in,
    output logic ack_in
);
    // ********************
    // Pin control
    // ********************
    // Rest levels: closed contacts high, start low, acknowledge high.
    initial begin
        {guard_door_closed_in, emergency_stop_ok_in, op_stop_ok_in, start_in, ack_in} = 5'h1d;
    end

    // Pins move just after an edge so the synchroniser never sees a race.
    task automatic after_edge;
        @(posedge sys_clk);
        #1;
    endtask

    // Door contact and stop buttons are levels that stay until changed again.
    task automatic open_door;
        after_edge();
        guard_door_closed_in = 1'b0;
    endtask

    task automatic close_door;
        after_edge();
        guard_door_closed_in = 1'b1;
    endtask

    task automatic press_estop;
        after_edge();
        emergency_stop_ok_in = 1'b0;
    endtask

    task automatic release_estop;
        after_edge();
        emergency_stop_ok_in = 1'b1;
    endtask

    task automatic press_stop;
        after_edge();
        op_stop_ok_in = 1'b0;
    endtask

    task automatic release_stop;
        after_edge();
        op_stop_ok_in = 1'b1;
    endtask

    // A press is held five cycles, long enough for two sync flops.
    task automatic push_start;
        after_edge();
        start_in = 1'b1;
        repeat (4) @(posedge sys_clk);
        after_edge();
        start_in = 1'b0;
    endtask

    // Acknowledge is taken on its falling edge, so the press drives it low.
    task automatic push_ack;
        after_edge();
        ack_in = 1'b0;
        repeat (4) @(posedge sys_clk);
        after_edge();
        ack_in = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the safety stop sequencer.
// Assumes a shortened standstill count of 20 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ********************
    // Clock, reset, design
    // ********************
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire logic door, estop, opstop, start, ack;
    logic ka, kb, run;
    int num_errors = 0;
    int checked = 0;

    // Free running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    operator_panel u_panel (.sys_clk(sys_clk), .guard_door_closed_in(door),
        .emergency_stop_ok_in(estop), .op_stop_ok_in(opstop), .start_in(start),
        .ack_in(ack));

    safety_stop_sequencer #(.STANDSTILL_CYCLES(20)) DUT (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .guard_door_closed_in(door), .emergency_stop_ok_in(estop),
        .op_stop_ok_in(opstop), .start_in(start), .ack_in(ack),
        .main_contactor_a(ka), .main_contactor_b(kb), .drive_run_command(run));

    // ********************
    // Helpers
    // ********************
    // Sample 2 ns after the edge so that registered outputs have settled.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    // Compare {contactor a, contactor b, run} with the expected levels.
    task automatic chk(input logic [2:0] e);
        checked++;
        if ({ka, kb, run} !== e) begin
            num_errors++;
            $display("ERROR %0t outputs %b expected %b", $time, {ka, kb, run}, e);
        end
    endtask

    task automatic final_report;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    // Expected values are {contactor a, contactor b, run}.
    task automatic t_powerup;
        chk(3'h0);
        u_panel.push_start();
        step(4);
        chk(3'h0);
        u_panel.push_ack();
        step(4);
        chk(3'h6);
        u_panel.push_start();
        step(4);
        chk(3'h7);
    endtask

    // Start is refused while the stop button is held, accepted after.
    task automatic t_opstop;
        u_panel.press_stop();
        step(5);
        chk(3'h6);
        u_panel.push_start();
        step(4);
        chk(3'h6);
        u_panel.release_stop();
        u_panel.push_start();
        step(4);
        chk(3'h7);
    endtask

    // The wait state is entered 3 edges after the press and lasts 20 edges:
    // contactors are still in one edge before the end and out two edges after.
    task automatic t_estop;
        u_panel.press_estop();
        step(5);
        chk(3'h6);
        u_panel.push_start();
        step(2);
        chk(3'h6);
        step(9);
        chk(3'h6);
        step(3);
        chk(3'h0);
        u_panel.release_estop();
        u_panel.push_start();
        step(4);
        chk(3'h0);
        u_panel.push_ack();
        step(4);
        chk(3'h6);
        u_panel.push_start();
        step(4);
        chk(3'h7);
    endtask

    // Door cut wins over a pending emergency delay and over acknowledge.
    task automatic t_door;
        u_panel.open_door();
        step(4);
        chk(3'h0);
        u_panel.push_ack();
        step(4);
        chk(3'h0);
        u_panel.close_door();
        u_panel.push_ack();
        step(4);
        chk(3'h6);
        u_panel.press_estop();
        step(3);
        u_panel.open_door();
        step(4);
        chk(3'h0);
    endtask

    // Main sequence after five cycles of reset.
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        step(2);
        t_powerup();
        t_opstop();
        t_estop();
        t_door();
        final_report();
    end

    // A hang counts as a mismatch and ends the run.
    initial begin
        #200000;
        num_errors++;
        $display("ERROR %0t run did not complete", $time);
        final_report();
    end
endmodule
`default_nettype wire
